// >>> core/rtc_alarm_pkg.sv
// constants of the alarm control block: register map, fields, codes
// assumes a 32-bit axi4-lite bus with byte addresses in 8 bits
package rtc_alarm_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_VAL_HIGH = 8'h04;
  localparam logic [7:0] OFF_VAL_LOW = 8'h08;
  localparam logic [7:0] OFF_CAL = 8'h0c;
  localparam logic [7:0] OFF_MINUTES_SECONDS_VALUE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam int CFG_ON = 15;
  localparam int CFG_CHIME = 14;
  localparam int CFG_SCOPE_LO = 10;
  localparam int CFG_PTR_LO = 8;
  localparam int CFG_RPT_LO = 0;
  localparam logic [7:0] RPT_ZERO = 8'h00;
  localparam logic [7:0] RPT_ONE = 8'h01;
  localparam logic [1:0] PTR_ZERO = 2'h0;
  localparam logic [1:0] PTR_NONE = 2'h3;
  localparam logic [2:0] HIGH_BASE = 3'h3;
  localparam int CAL_RUN = 0;
  localparam int CAL_UNLOCK = 1;
  localparam int CAL_SYNC = 2;
  localparam logic [2:0] CAL_RESET = 3'h0;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_DONE = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] FEB = 8'h02;
  localparam logic [7:0] DAY_29 = 8'h29;
  typedef enum logic [3:0] {
    SCOPE_HALF = 4'b0000,
    SCOPE_SEC = 4'b0001,
    SCOPE_TEN_SEC = 4'b0010,
    SCOPE_MIN = 4'b0011,
    SCOPE_TEN_MIN = 4'b0100,
    SCOPE_HOUR = 4'b0101,
    SCOPE_DAY = 4'b0110,
    SCOPE_WEEK = 4'b0111,
    SCOPE_MONTH = 4'b1000,
    SCOPE_YEAR = 4'b1001
  } scope_t;
endpackage

// >>> core/rtc_alarm_match.sv
// alarm comparator: current time against stored alarm fields
// assumes bcd time fields and tick pulses synchronous to the clock
`timescale 1ns/1ns
module rtc_alarm_match (
  // ticks
  input wire logic half_tick,
  input wire logic sec_tick,
  // current time
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_wday,
  input wire logic [7:0] cur_day,
  input wire logic [7:0] cur_month,
  input wire logic leap_year,
  // alarm setting
  input wire logic [7:0] al_sec,
  input wire logic [7:0] al_min,
  input wire logic [7:0] al_hour,
  input wire logic [7:0] al_wday,
  input wire logic [7:0] al_day,
  input wire logic [7:0] al_month,
  input wire logic [3:0] scope,
  // result
  output logic match
);
  logic s1;
  logic s;
  logic m1;
  logic m;
  logic h;
  logic feb29_ok;
  always_comb begin
    s1 = cur_sec[3:0] == al_sec[3:0];
    s = cur_sec == al_sec;
    m1 = s && cur_min[3:0] == al_min[3:0];
    m = s && cur_min == al_min;
    h = m && cur_hour == al_hour;
    // feb 29 only fires in a leap year
    feb29_ok = !(al_month == rtc_alarm_pkg::FEB && al_day == rtc_alarm_pkg::DAY_29) || leap_year;
    case (scope)
      rtc_alarm_pkg::SCOPE_HALF: match = half_tick;
      rtc_alarm_pkg::SCOPE_SEC: match = sec_tick;
      rtc_alarm_pkg::SCOPE_TEN_SEC: match = sec_tick && s1;
      rtc_alarm_pkg::SCOPE_MIN: match = sec_tick && s;
      rtc_alarm_pkg::SCOPE_TEN_MIN: match = sec_tick && m1;
      rtc_alarm_pkg::SCOPE_HOUR: match = sec_tick && m;
      rtc_alarm_pkg::SCOPE_DAY: match = sec_tick && h;
      rtc_alarm_pkg::SCOPE_WEEK: match = sec_tick && h && cur_wday == al_wday;
      rtc_alarm_pkg::SCOPE_MONTH: match = sec_tick && h && cur_day == al_day;
      rtc_alarm_pkg::SCOPE_YEAR: begin
        match = sec_tick && h && cur_day == al_day && cur_month == al_month
          && feb29_ok;
      end
      default: match = 1'b0;
    endcase
  end
endmodule

// >>> core/rtc_alarm_control.sv
// alarm configuration, repeat and value window logic with axi4-lite slave
// assumes time fields and ticks come from the calendar counters, same clock
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// Behaviour
// - alarm off gives no events; after an event with count zero and chime off it turns off.
// - each event decrements the repeat count, wrapping from zero only with chime on.
// - with chime off, the repeat count says how many further events follow, zero meaning none.
// - the pointer picks which alarm value appears in the high and low windows.
// - each access to the high window decrements the pointer, stopping at zero.
// - the calibration register is reset only by power-on reset.
// - writes to the run-enable bit are ignored unless write-unlock is set.
// - writing the low half of minutes/seconds clears the read-only sync bit.
// - all sixteen configuration bits are read/write and reset to zero.
module rtc_alarm_control (
  // clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // time base
  input wire logic half_tick,
  input wire logic sec_tick,
  input wire logic [7:0] cur_sec,
  input wire logic [7:0] cur_min,
  input wire logic [7:0] cur_hour,
  input wire logic [7:0] cur_wday,
  input wire logic [7:0] cur_day,
  input wire logic [7:0] cur_month,
  input wire logic leap_year,
  // outputs
  output logic alarm_event,
  output logic clock_run_enable,
  output logic irq
);
  logic alarm_on, chime, clock_write_unlock, cal_sync, aw_held, w_held;
  logic wr_go, rd_go, wr_hit, rd_hit, rd_hi, wr_hi, wr_lo, match, fire;
  logic [1:0] alarm_value_pointer, irq_status, irq_mask;
  logic [3:0] alarm_match_scope, w_strb;
  logic [7:0] alarm_repeat_count, aw_addr;
  logic [7:0] alarm_val [0:5];
  logic [2:0] wr_idx, rd_idx;
  logic [15:0] minutes_seconds_value, config_word;
  logic [31:0] w_data, next_rdata;

  rtc_alarm_match u_match (
    .half_tick(half_tick),
    .sec_tick(sec_tick),
    .cur_sec(cur_sec),
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .cur_wday(cur_wday),
    .cur_day(cur_day),
    .cur_month(cur_month),
    .leap_year(leap_year),
    .al_sec(alarm_val[0]),
    .al_hour(alarm_val[1]),
    .al_day(alarm_val[2]),
    .al_min(alarm_val[3]),
    .al_wday(alarm_val[4]),
    .al_month(alarm_val[5]),
    .scope(alarm_match_scope),
    .match(match)
  );

  assign fire = match && alarm_on;
  assign config_word = {alarm_on, chime, alarm_match_scope, alarm_value_pointer,
    alarm_repeat_count};
  assign wr_go = aw_held && w_held && !bvalid;
  assign rd_go = arvalid && arready;
  assign wr_hi = wr_go && aw_addr == rtc_alarm_pkg::OFF_VAL_HIGH;
  assign wr_lo = wr_go && aw_addr == rtc_alarm_pkg::OFF_VAL_LOW;
  assign rd_hi = rd_go && araddr == rtc_alarm_pkg::OFF_VAL_HIGH;
  // window index: low window 0..2, high window 3..5
  assign wr_idx = wr_hi ? rtc_alarm_pkg::HIGH_BASE + {1'b0, alarm_value_pointer}
    : {1'b0, alarm_value_pointer};
  assign rd_idx = (araddr == rtc_alarm_pkg::OFF_VAL_HIGH)
    ? rtc_alarm_pkg::HIGH_BASE + {1'b0, alarm_value_pointer} : {1'b0, alarm_value_pointer};

  always_comb begin
    case (aw_addr)
      rtc_alarm_pkg::OFF_CONFIG, rtc_alarm_pkg::OFF_VAL_HIGH, rtc_alarm_pkg::OFF_VAL_LOW,
      rtc_alarm_pkg::OFF_CAL, rtc_alarm_pkg::OFF_MINUTES_SECONDS_VALUE, rtc_alarm_pkg::OFF_IRQ_STATUS,
      rtc_alarm_pkg::OFF_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    case (araddr)
      rtc_alarm_pkg::OFF_CONFIG: next_rdata[15:0] = config_word;
      rtc_alarm_pkg::OFF_VAL_HIGH, rtc_alarm_pkg::OFF_VAL_LOW: begin
        if (alarm_value_pointer != rtc_alarm_pkg::PTR_NONE) begin
          next_rdata[7:0] = alarm_val[rd_idx];
        end
      end
      rtc_alarm_pkg::OFF_CAL: begin
        next_rdata[rtc_alarm_pkg::CAL_RUN] = clock_run_enable;
        next_rdata[rtc_alarm_pkg::CAL_UNLOCK] = clock_write_unlock;
        next_rdata[rtc_alarm_pkg::CAL_SYNC] = cal_sync;
      end
      rtc_alarm_pkg::OFF_MINUTES_SECONDS_VALUE: next_rdata[15:0] = minutes_seconds_value;
      rtc_alarm_pkg::OFF_IRQ_STATUS: next_rdata[1:0] = irq_status;
      rtc_alarm_pkg::OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
      default: rd_hit = 1'b0;
    endcase
  end

  // write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      awready <= 1'b0;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      aw_addr <= awaddr;
    end else if (bvalid && bready) begin
      aw_held <= 1'b0;
      awready <= 1'b1;
    end else if (!aw_held) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      wready <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      wready <= 1'b0;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (bvalid && bready) begin
      w_held <= 1'b0;
      wready <= 1'b1;
    end else if (!w_held) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= rtc_alarm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? rtc_alarm_pkg::RESP_OKAY : rtc_alarm_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel, one outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= rtc_alarm_pkg::RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= rd_hit ? rtc_alarm_pkg::RESP_OKAY : rtc_alarm_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // alarm enable, chime, scope
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_on <= rtc_alarm_pkg::CONFIG_RESET[rtc_alarm_pkg::CFG_ON];
      chime <= rtc_alarm_pkg::CONFIG_RESET[rtc_alarm_pkg::CFG_CHIME];
      alarm_match_scope <= rtc_alarm_pkg::CONFIG_RESET[rtc_alarm_pkg::CFG_SCOPE_LO +: 4];
    end else if (wr_go && aw_addr == rtc_alarm_pkg::OFF_CONFIG && w_strb[1]) begin
      alarm_on <= w_data[rtc_alarm_pkg::CFG_ON];
      chime <= w_data[rtc_alarm_pkg::CFG_CHIME];
      alarm_match_scope <= w_data[rtc_alarm_pkg::CFG_SCOPE_LO +: 4];
    end else if (fire && !chime && alarm_repeat_count == rtc_alarm_pkg::RPT_ZERO) begin
      alarm_on <= 1'b0;
    end
  end
  property p_auto_off;
    @(posedge aclk) disable iff (!aresetn)
      fire && !chime && alarm_repeat_count == rtc_alarm_pkg::RPT_ZERO && !wr_go |=> !alarm_on;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("alarm not auto-disabled");
  property p_reset_zero;
    @(posedge aclk) $past(!aresetn) && !aresetn |-> config_word == rtc_alarm_pkg::CONFIG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not zero");
  // repeat counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_repeat_count <= rtc_alarm_pkg::CONFIG_RESET[rtc_alarm_pkg::CFG_RPT_LO +: 8];
    end else if (wr_go && aw_addr == rtc_alarm_pkg::OFF_CONFIG && w_strb[0]) begin
      alarm_repeat_count <= w_data[rtc_alarm_pkg::CFG_RPT_LO +: 8];
    end else if (fire && (chime || alarm_repeat_count != rtc_alarm_pkg::RPT_ZERO)) begin
      alarm_repeat_count <= alarm_repeat_count - rtc_alarm_pkg::RPT_ONE;
    end
  end
  property p_count_dec;
    @(posedge aclk) disable iff (!aresetn)
      fire && alarm_repeat_count != rtc_alarm_pkg::RPT_ZERO && !wr_go
      |=> alarm_repeat_count == $past(alarm_repeat_count) - rtc_alarm_pkg::RPT_ONE;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented");
  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
      fire && alarm_repeat_count == rtc_alarm_pkg::RPT_ZERO && !wr_go
      |=> alarm_repeat_count == ($past(chime) ? 8'hff : rtc_alarm_pkg::RPT_ZERO);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrong wrap of repeat count");
  // value window pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_value_pointer <= rtc_alarm_pkg::CONFIG_RESET[rtc_alarm_pkg::CFG_PTR_LO +: 2];
    end else if (wr_go && aw_addr == rtc_alarm_pkg::OFF_CONFIG && w_strb[1]) begin
      alarm_value_pointer <= w_data[rtc_alarm_pkg::CFG_PTR_LO +: 2];
    end else if ((rd_hi || wr_hi) && alarm_value_pointer != rtc_alarm_pkg::PTR_ZERO) begin
      alarm_value_pointer <= alarm_value_pointer - 2'h1;
    end
  end
  property p_ptr_dec;
    @(posedge aclk) disable iff (!aresetn)
      rd_hi && !wr_go |=> alarm_value_pointer == ($past(alarm_value_pointer)
        == rtc_alarm_pkg::PTR_ZERO ? rtc_alarm_pkg::PTR_ZERO : $past(alarm_value_pointer) - 2'h1);
  endproperty
  a_ptr_dec: assert property (p_ptr_dec) else $error("pointer step wrong");
  // alarm value registers behind the windows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 6; i++) begin
        alarm_val[i] <= 8'h00;
      end
    end else if ((wr_hi || wr_lo) && w_strb[0]
      && alarm_value_pointer != rtc_alarm_pkg::PTR_NONE) begin
      alarm_val[wr_idx] <= w_data[7:0];
    end
  end

  // calibration register, power-on reset only
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      clock_run_enable <= rtc_alarm_pkg::CAL_RESET[rtc_alarm_pkg::CAL_RUN];
      clock_write_unlock <= rtc_alarm_pkg::CAL_RESET[rtc_alarm_pkg::CAL_UNLOCK];
    end else if (wr_go && aw_addr == rtc_alarm_pkg::OFF_CAL && w_strb[0]) begin
      clock_write_unlock <= w_data[rtc_alarm_pkg::CAL_UNLOCK];
      if (clock_write_unlock) begin
        clock_run_enable <= w_data[rtc_alarm_pkg::CAL_RUN];
      end
    end
  end
  property p_run_locked;
    @(posedge aclk) disable iff (!por_n) !clock_write_unlock |=> $stable(clock_run_enable);
  endproperty
  a_run_locked: assert property (p_run_locked) else $error("locked run bit changed");
  // sync status: set by the half-second tick, cleared by a low-half write
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      cal_sync <= rtc_alarm_pkg::CAL_RESET[rtc_alarm_pkg::CAL_SYNC];
    end else if (half_tick) begin
      cal_sync <= 1'b1;
    end else if (wr_go && aw_addr == rtc_alarm_pkg::OFF_MINUTES_SECONDS_VALUE && w_strb[0]) begin
      cal_sync <= 1'b0;
    end
  end
  property p_sync_clear;
    @(posedge aclk) disable iff (!por_n || !aresetn)
      wr_go && aw_addr == rtc_alarm_pkg::OFF_MINUTES_SECONDS_VALUE && w_strb[0] && !half_tick |=> !cal_sync;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync bit not cleared");
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      minutes_seconds_value <= 16'h0000;
    end else if (wr_go && aw_addr == rtc_alarm_pkg::OFF_MINUTES_SECONDS_VALUE) begin
      if (w_strb[0]) begin
        minutes_seconds_value[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        minutes_seconds_value[15:8] <= w_data[15:8];
      end
    end
  end

  // interrupt status, write one to clear; a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= rtc_alarm_pkg::IRQ_RESET;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (wr_go && aw_addr == rtc_alarm_pkg::OFF_IRQ_STATUS && w_strb[0] && w_data[b]) begin
          irq_status[b] <= 1'b0;
        end
      end
      if (fire) begin
        irq_status[rtc_alarm_pkg::IRQ_ALARM] <= 1'b1;
      end
      if (fire && !chime && alarm_repeat_count == rtc_alarm_pkg::RPT_ZERO) begin
        irq_status[rtc_alarm_pkg::IRQ_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= rtc_alarm_pkg::IRQ_RESET;
    end else if (wr_go && aw_addr == rtc_alarm_pkg::OFF_IRQ_MASK && w_strb[0]) begin
      irq_mask <= w_data[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      alarm_event <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
      alarm_event <= fire;
    end
  end
  property p_off_silent;
    @(posedge aclk) disable iff (!aresetn) !alarm_on |=> !alarm_event;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("event while alarm off");
  property p_event_irq;
    @(posedge aclk) disable iff (!aresetn)
      fire |=> irq_status[rtc_alarm_pkg::IRQ_ALARM] && alarm_event;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("event not flagged");
endmodule

// >>> sim/testbench.sv
// self-checking bench for the alarm control block
// assumes an axi4-lite slave with one write and one read in flight, one clock at 50 MHz
`timescale 1ns/1ns
module testbench;
  logic aclk, aresetn, por_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic half_tick, sec_tick, leap_year, alarm_event, clock_run_enable, irq;
  logic [7:0] cur_sec, cur_min, cur_hour, cur_wday, cur_day, cur_month;
  int bad_count, n_tests, cycles, n;

  rtc_alarm_control dut_u (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .half_tick(half_tick), .sec_tick(sec_tick),
    .cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour), .cur_wday(cur_wday),
    .cur_day(cur_day), .cur_month(cur_month), .leap_year(leap_year),
    .alarm_event(alarm_event), .clock_run_enable(clock_run_enable), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // let an edge pass so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hf, rsp);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input string what);
    axi_read(a, rd, rsp);
    check(rd, exp, what);
  endtask

  function automatic logic [31:0] cfg(input logic on, input logic ch, input logic [3:0] sc,
                                      input logic [1:0] p, input logic [7:0] rpt);
    return {16'h0000, on, ch, sc, p, rpt};
  endfunction

  // one tick pulse, then count alarm pulses that follow
  task automatic tick(input logic h, input logic s, output int cnt);
    half_tick <= h;
    sec_tick <= s;
    @(posedge aclk);
    half_tick <= 1'b0;
    sec_tick <= 1'b0;
    cnt = 0;
    repeat (3) begin
      @(posedge aclk);
      if (alarm_event === 1'b1) cnt++;
    end
  endtask

  // fills all six alarm fields through the two windows
  task automatic set_alarm(input logic [7:0] s, mi, h, wd, dy, mo);
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h2, 8'h00));
    wr(rtc_alarm_pkg::OFF_VAL_HIGH, {24'h0, mo});
    wr(rtc_alarm_pkg::OFF_VAL_HIGH, {24'h0, wd});
    wr(rtc_alarm_pkg::OFF_VAL_HIGH, {24'h0, mi});
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h2, 8'h00));
    wr(rtc_alarm_pkg::OFF_VAL_LOW, {24'h0, dy});
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h1, 8'h00));
    wr(rtc_alarm_pkg::OFF_VAL_LOW, {24'h0, h});
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h0, 8'h00));
    wr(rtc_alarm_pkg::OFF_VAL_LOW, {24'h0, s});
  endtask

  initial begin
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    aresetn = 1'b0;
    por_n = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, half_tick, sec_tick, leap_year} = '0;
    {cur_sec, cur_min, cur_hour} = {8'h30, 8'h15, 8'h08};
    {cur_wday, cur_day, cur_month} = {8'h03, 8'h17, 8'h05};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge aclk);
    check({30'h0, irq, alarm_event}, 32'h0, "outputs after reset");
    rdx(rtc_alarm_pkg::OFF_CONFIG, 32'h0000_0000, "config reset");
    wr(rtc_alarm_pkg::OFF_CONFIG, 32'h0000_bdff);
    rdx(rtc_alarm_pkg::OFF_CONFIG, 32'h0000_bdff, "config all bits");
    wr(rtc_alarm_pkg::OFF_CONFIG, 32'h0000_0000);
    axi_read(8'h1c, rd, rsp);
    check({rd[29:0], rsp}, {30'h0, rtc_alarm_pkg::RESP_SLVERR}, "unmapped read");
    axi_write(8'h20, 32'h0000_ffff, 4'hf, rsp);
    check({30'h0, rsp}, {30'h0, rtc_alarm_pkg::RESP_SLVERR}, "unmapped write");
    // windows and pointer walk
    set_alarm(8'h30, 8'h15, 8'h08, 8'h03, 8'h17, 8'h06);
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h2, 8'h00));
    rdx(rtc_alarm_pkg::OFF_VAL_HIGH, 32'h0000_0006, "high month");
    rdx(rtc_alarm_pkg::OFF_VAL_HIGH, 32'h0000_0003, "high weekday");
    rdx(rtc_alarm_pkg::OFF_VAL_HIGH, 32'h0000_0015, "high minutes");
    rdx(rtc_alarm_pkg::OFF_VAL_HIGH, 32'h0000_0015, "pointer held at zero");
    rdx(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h0, 8'h00), "pointer field");
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h2, 8'h00));
    rdx(rtc_alarm_pkg::OFF_VAL_LOW, 32'h0000_0017, "low day");
    rdx(rtc_alarm_pkg::OFF_VAL_LOW, 32'h0000_0017, "low keeps pointer");
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h1, 8'h00));
    rdx(rtc_alarm_pkg::OFF_VAL_LOW, 32'h0000_0008, "low hours");
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(0, 0, 4'h0, 2'h3, 8'h00));
    rdx(rtc_alarm_pkg::OFF_VAL_LOW, 32'h0000_0000, "low unimplemented");
    // every scope with the month field off by one
    for (int s = 1; s <= 9; s++) begin
      wr(rtc_alarm_pkg::OFF_CONFIG, cfg(1, 1, s[3:0], 2'h0, 8'h00));
      tick(1'b1, 1'b1, n);
      check(n, (s == 9) ? 0 : 1, "scope event count");
    end
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(1, 1, 4'h0, 2'h0, 8'h00));
    tick(1'b1, 1'b0, n);
    check(n, 1, "half second scope");
    // repeat count runs down, then the alarm turns itself off
    wr(rtc_alarm_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(1, 0, 4'h0, 2'h0, 8'h02));
    for (int i = 0; i < 4; i++) begin
      tick(1'b1, 1'b0, n);
      check(n, (i < 3) ? 1 : 0, "repeat sequence");
    end
    rdx(rtc_alarm_pkg::OFF_CONFIG, 32'h0000_0000, "auto disable");
    rdx(rtc_alarm_pkg::OFF_IRQ_STATUS, 32'h0000_0003, "status set");
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(rtc_alarm_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    @(posedge aclk);
    check({31'h0, irq}, 32'h1, "irq unmasked");
    wr(rtc_alarm_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    @(posedge aclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rdx(rtc_alarm_pkg::OFF_IRQ_STATUS, 32'h0000_0002, "status w1c");
    // chime lets the count wrap
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(1, 1, 4'h0, 2'h0, 8'h00));
    tick(1'b1, 1'b0, n);
    rdx(rtc_alarm_pkg::OFF_CONFIG, cfg(1, 1, 4'h0, 2'h0, 8'hff), "chime wrap");
    // yearly alarm on the leap day
    set_alarm(8'h30, 8'h15, 8'h08, 8'h03, 8'h29, 8'h02);
    cur_day <= 8'h29;
    cur_month <= 8'h02;
    wr(rtc_alarm_pkg::OFF_CONFIG, cfg(1, 1, 4'h9, 2'h0, 8'h00));
    tick(1'b1, 1'b1, n);
    check(n, 0, "leap day, common year");
    leap_year <= 1'b1;
    tick(1'b1, 1'b1, n);
    check(n, 1, "leap day, leap year");
    // calibration register
    wr(rtc_alarm_pkg::OFF_CONFIG, 32'h0000_0000);
    wr(rtc_alarm_pkg::OFF_CAL, 32'h0000_0001);
    check({31'h0, clock_run_enable}, 32'h0, "run locked");
    wr(rtc_alarm_pkg::OFF_CAL, 32'h0000_0002);
    wr(rtc_alarm_pkg::OFF_CAL, 32'h0000_0003);
    check({31'h0, clock_run_enable}, 32'h1, "run unlocked");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({31'h0, clock_run_enable}, 32'h1, "run kept over reset");
    rdx(rtc_alarm_pkg::OFF_CONFIG, 32'h0000_0000, "config after reset");
    tick(1'b1, 1'b0, n);
    check(n, 0, "alarm off");
    axi_read(rtc_alarm_pkg::OFF_CAL, rd, rsp);
    check({29'h0, rd[2:0]}, 32'h0000_0007, "cal kept, sync set");
    axi_write(rtc_alarm_pkg::OFF_MINUTES_SECONDS_VALUE, 32'h0000_0000, 4'h1, rsp);
    axi_read(rtc_alarm_pkg::OFF_CAL, rd, rsp);
    check({31'h0, rd[2]}, 32'h0, "sync cleared");
    por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    por_n <= 1'b1;
    @(posedge aclk);
    check({31'h0, clock_run_enable}, 32'h0, "power-on clears run");
    complete_run();
  end
endmodule
